/* File: core/comparator_edge_flag_control.sv */
// Comparator control, sticky edge flags and interrupt request
`timescale 1ns/100ps
`default_nettype none
module comparator_edge_flag_control #(
	parameter int HYST_BITS = cmp_edge_pkg::HYST_WIDTH
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_cmp_raw,
	input wire logic i_ctrl_wr,
	input wire logic [cmp_edge_pkg::CTRL_WIDTH-1:0] i_ctrl_wdata,
	input wire logic i_irq_enable,
	output logic [cmp_edge_pkg::CTRL_WIDTH-1:0] o_comparator_control_reg,
	output logic o_cmp_enable_bit,
	output logic [HYST_BITS-1:0] o_neg_hyst_select,
	output logic [HYST_BITS-1:0] o_pos_hyst_select,
	output logic o_rise_edge_flag,
	output logic o_fall_edge_flag,
	output logic o_cmp_output_state,
	output logic o_irq
);
	// ------------------------------------------------------------
	// Reset synchroniser
	// ------------------------------------------------------------
	logic rst_meta;
	logic rst_n;
	logic next_rst_meta;
	logic next_rst_n;

	// Assert at once, release only after two clean edges
	always_comb begin
		next_rst_meta = 1'b1;
		next_rst_n = rst_meta;
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= next_rst_meta;
			rst_n <= next_rst_n;
		end
	end

	// ------------------------------------------------------------
	// Comparator input path
	// ------------------------------------------------------------
	cmp_edge_if edges ();

	cmp_sync_edge u_sync (
		.i_clk(i_core_clk),
		.i_rst_n(rst_n),
		.i_cmp_raw(i_cmp_raw),
		.edges(edges)
	);

	// ------------------------------------------------------------
	// Control fields and sticky flags
	// ------------------------------------------------------------
	logic enable;
	logic [HYST_BITS-1:0] neg_hyst;
	logic [HYST_BITS-1:0] pos_hyst;
	logic rise_flag;
	logic fall_flag;
	logic next_enable;
	logic [HYST_BITS-1:0] next_neg_hyst;
	logic [HYST_BITS-1:0] next_pos_hyst;
	logic next_rise_flag;
	logic next_fall_flag;

	// A write replaces the flags, but an edge in the same cycle still
	// sets them so no event is lost while software clears
	always_comb begin
		next_enable = enable;
		next_neg_hyst = neg_hyst;
		next_pos_hyst = pos_hyst;
		next_rise_flag = rise_flag;
		next_fall_flag = fall_flag;
		if (i_ctrl_wr) begin
			next_enable = i_ctrl_wdata[cmp_edge_pkg::BIT_ENABLE];
			next_neg_hyst = i_ctrl_wdata[cmp_edge_pkg::NEG_HYST_LSB
				+: HYST_BITS];
			next_pos_hyst = i_ctrl_wdata[cmp_edge_pkg::POS_HYST_LSB
				+: HYST_BITS];
			next_rise_flag = i_ctrl_wdata[cmp_edge_pkg::BIT_RISE];
			next_fall_flag = i_ctrl_wdata[cmp_edge_pkg::BIT_FALL];
		end
		// Edges set regardless of the interrupt enable
		if (edges.rise) begin
			next_rise_flag = 1'b1;
		end
		if (edges.fall) begin
			next_fall_flag = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable <= cmp_edge_pkg::ENABLE_RESET;
			neg_hyst <= HYST_BITS'(cmp_edge_pkg::HYST_RESET);
			pos_hyst <= HYST_BITS'(cmp_edge_pkg::HYST_RESET);
			rise_flag <= cmp_edge_pkg::FLAG_RESET;
			fall_flag <= cmp_edge_pkg::FLAG_RESET;
		end else begin
			enable <= next_enable;
			neg_hyst <= next_neg_hyst;
			pos_hyst <= next_pos_hyst;
			rise_flag <= next_rise_flag;
			fall_flag <= next_fall_flag;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Hysteresis codes go straight to the analog core; code zero is off
	assign o_cmp_enable_bit = enable;
	assign o_neg_hyst_select = neg_hyst;
	assign o_pos_hyst_select = pos_hyst;
	assign o_rise_edge_flag = rise_flag;
	assign o_fall_edge_flag = fall_flag;
	assign o_cmp_output_state = edges.level;

	// Request is level: it stays up until software clears both flags or i_irq_enable goes low
	assign o_irq = i_irq_enable & (rise_flag | fall_flag);

	// Read-back view of the whole control register
	always_comb begin
		o_comparator_control_reg = '0;
		o_comparator_control_reg[cmp_edge_pkg::BIT_ENABLE] = enable;
		o_comparator_control_reg[cmp_edge_pkg::BIT_OUTPUT] = edges.level;
		o_comparator_control_reg[cmp_edge_pkg::BIT_RISE] = rise_flag;
		o_comparator_control_reg[cmp_edge_pkg::BIT_FALL] = fall_flag;
		o_comparator_control_reg[cmp_edge_pkg::POS_HYST_LSB +: HYST_BITS] =
			pos_hyst;
		o_comparator_control_reg[cmp_edge_pkg::NEG_HYST_LSB +: HYST_BITS] =
			neg_hyst;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!rst_n);

	// Write-data hysteresis fields as the checks expect to see them
	logic [HYST_BITS-1:0] wr_neg_hyst;
	logic [HYST_BITS-1:0] wr_pos_hyst;
	assign wr_neg_hyst =
		i_ctrl_wdata[cmp_edge_pkg::NEG_HYST_LSB +: HYST_BITS];
	assign wr_pos_hyst =
		i_ctrl_wdata[cmp_edge_pkg::POS_HYST_LSB +: HYST_BITS];

	chk_rise_sets_flag: assert property (
		edges.rise |=> o_rise_edge_flag)
		else $error("rising edge did not set rise flag");

	chk_fall_sets_flag: assert property (
		edges.fall |=> o_fall_edge_flag)
		else $error("falling edge did not set fall flag");

	chk_rise_flag_sticky: assert property (
		(o_rise_edge_flag && !(i_ctrl_wr &&
			!i_ctrl_wdata[cmp_edge_pkg::BIT_RISE])) |=> o_rise_edge_flag)
		else $error("rise flag cleared without software write");

	chk_fall_flag_sticky: assert property (
		(o_fall_edge_flag && !(i_ctrl_wr &&
			!i_ctrl_wdata[cmp_edge_pkg::BIT_FALL])) |=> o_fall_edge_flag)
		else $error("fall flag cleared without software write");

	chk_enable_write: assert property (
		i_ctrl_wr |=> o_cmp_enable_bit ==
			$past(i_ctrl_wdata[cmp_edge_pkg::BIT_ENABLE]))
		else $error("enable bit does not follow write");

	chk_hyst_fields: assert property (
		i_ctrl_wr |=> (o_neg_hyst_select == $past(wr_neg_hyst))
			&& (o_pos_hyst_select == $past(wr_pos_hyst)))
		else $error("hysteresis fields do not follow write");

	chk_level_tracks: assert property (
		i_cmp_raw [*3] |-> o_cmp_output_state)
		else $error("output state does not track comparator");

	chk_soft_set_irq: assert property (
		(i_ctrl_wr && i_ctrl_wdata[cmp_edge_pkg::BIT_RISE])
			##1 i_irq_enable |-> o_irq)
		else $error("software set of flag gave no request");

	chk_edge_irq: assert property (
		(edges.fall || edges.rise) ##1 i_irq_enable |-> o_irq)
		else $error("edge did not raise request");

	chk_flag_no_enable: assert property (
		(edges.rise && !i_irq_enable) |=> o_rise_edge_flag)
		else $error("rise flag not set while interrupt disabled");

	// An edge in the cycle of a clearing write must still leave the flag
	chk_rise_set_wins: assert property (
		(edges.rise && i_ctrl_wr &&
			!i_ctrl_wdata[cmp_edge_pkg::BIT_RISE])
			|=> o_rise_edge_flag)
		else $error("clearing write swallowed a rising edge");

	chk_fall_set_wins: assert property (
		(edges.fall && i_ctrl_wr &&
			!i_ctrl_wdata[cmp_edge_pkg::BIT_FALL])
			|=> o_fall_edge_flag)
		else $error("clearing write swallowed a falling edge");

	// A pulse needs the raw level two edges back; one flop would be early
	chk_rise_sync_depth: assert property (
		edges.rise |-> $past(i_cmp_raw, 2))
		else $error("rising pulse came before two sync stages");

	chk_fall_sync_depth: assert property (
		edges.fall |-> !$past(i_cmp_raw, 2))
		else $error("falling pulse came before two sync stages");

	chk_irq_masked: assert property (
		!i_irq_enable |-> !o_irq)
		else $error("request raised while interrupt disabled");

	// ------------------------------------------------------------
	// Coverage of the main scenarios
	// ------------------------------------------------------------
	cov_rise_edge: cover property (edges.rise ##1 o_rise_edge_flag);
	cov_fall_edge: cover property (edges.fall ##1 o_fall_edge_flag);
	cov_clear_race: cover property (i_ctrl_wr && edges.rise);
	cov_irq_up: cover property (!o_irq ##1 o_irq);
	cov_soft_set: cover property (
		i_ctrl_wr && i_ctrl_wdata[cmp_edge_pkg::BIT_FALL]);
endmodule : comparator_edge_flag_control
`default_nettype wire

/* File: core/cmp_edge_pkg.sv */
// Constants for the comparator edge flag control block
//
// Function
// - Hysteresis settings come from the low four bits of comparator_control_reg, split into a negative and a positive field.
// - The negative field picks one of several negative hysteresis levels for the comparator core, and one code turns it off.
// - The positive field picks the positive hysteresis level on its own, in the same way.
// - Interrupt requests can come from both rising and falling comparator output transitions.
// - A high-to-low comparator transition sets fall_edge_flag to 1.
// - A low-to-high comparator transition sets rise_edge_flag to 1.
// - Both flags stay set and hardware never clears them; software clears each by writing it.
// - cmp_output_state shows the current comparator level at any time.
// - Writing 1 to cmp_enable_bit turns the comparator on and writing 0 turns it off.
// - Each flag is set on its edge whether or not the interrupt is enabled.
// - Software writing 1 to a flag sets it and, when enabled, raises a request like a real edge.
package cmp_edge_pkg;
	// ------------------------------------------------------------
	// Control register layout
	// ------------------------------------------------------------
	localparam int CTRL_WIDTH = 8;
	localparam int HYST_WIDTH = 2;
	localparam int BIT_ENABLE = 7;
	localparam int BIT_OUTPUT = 6;
	localparam int BIT_RISE = 5;
	localparam int BIT_FALL = 4;
	localparam int POS_HYST_LSB = 2;
	localparam int NEG_HYST_LSB = 0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [HYST_WIDTH-1:0] HYST_RESET = 2'h0;
	localparam logic ENABLE_RESET = 1'b0;
	localparam logic FLAG_RESET = 1'b0;
endpackage : cmp_edge_pkg

/* File: core/cmp_edge_if.sv */
// Interface carrying the synchronised comparator level and edge pulses
`timescale 1ns/100ps
`default_nettype none
interface cmp_edge_if;
	logic level;
	logic rise;
	logic fall;

	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface : cmp_edge_if
`default_nettype wire

/* File: core/cmp_sync_edge.sv */
// Comparator output synchroniser and edge detector
`timescale 1ns/100ps
`default_nettype none
module cmp_sync_edge (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_cmp_raw,
	cmp_edge_if.src edges
);
	logic meta;
	logic stable;
	logic delayed;
	logic next_meta;
	logic next_stable;
	logic next_delayed;

	// ------------------------------------------------------------
	// Synchroniser chain
	// ------------------------------------------------------------
	// The raw comparator is asynchronous; meta is read only by stable
	always_comb begin
		next_meta = i_cmp_raw;
		next_stable = meta;
		next_delayed = stable;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= 1'b0;
			stable <= 1'b0;
			delayed <= 1'b0;
		end else begin
			meta <= next_meta;
			stable <= next_stable;
			delayed <= next_delayed;
		end
	end

	// ------------------------------------------------------------
	// Edge pulses, one cycle wide
	// ------------------------------------------------------------
	assign edges.level = stable;
	assign edges.rise = stable & ~delayed;
	assign edges.fall = ~stable & delayed;
endmodule : cmp_sync_edge
`default_nettype wire

/* File: bench/cmp_core_model.sv */
// Behavioural stand-in for the analog comparator core
`timescale 1ns/100ps
`default_nettype none
module cmp_core_model (
	input wire logic i_target,
	input wire logic i_slow,
	output logic o_raw
);
	// ------------------------------------------------------------
	// Output settles after a short or a long analog delay
	// ------------------------------------------------------------
	// Both delays stay inside half a clock so a change lands before
	// the next rising edge, as the bench schedules its waits
	initial o_raw = 1'b0;
	always @(i_target) begin
		o_raw <= #(i_slow ? 8 : 2) i_target;
	end
endmodule : cmp_core_model
`default_nettype wire

/* File: bench/test_comparator_edge_flag_control.sv */
// Self-checking bench for the comparator edge flag control block
`timescale 1ns/100ps
`default_nettype none
module test_comparator_edge_flag_control;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic target = 1'b0;
	logic slow = 1'b0;
	logic cmp_raw;
	logic ctrl_wr = 1'b0;
	logic [7:0] ctrl_wdata = 8'h00;
	logic irq_enable = 1'b0;
	logic [7:0] ctrl;
	logic enable, rise, fall, out_state, irq;
	logic [1:0] neg, pos;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;

	// ------------------------------------------------------------
	// Design, comparator stand-in and clock
	// ------------------------------------------------------------
	comparator_edge_flag_control i_comparator_edge_flag_control (
		.i_core_clk(core_clk),
		.i_nrst(nrst),
		.i_cmp_raw(cmp_raw),
		.i_ctrl_wr(ctrl_wr),
		.i_ctrl_wdata(ctrl_wdata),
		.i_irq_enable(irq_enable),
		.o_comparator_control_reg(ctrl),
		.o_cmp_enable_bit(enable),
		.o_neg_hyst_select(neg),
		.o_pos_hyst_select(pos),
		.o_rise_edge_flag(rise),
		.o_fall_edge_flag(fall),
		.o_cmp_output_state(out_state),
		.o_irq(irq)
	);
	cmp_core_model i_cmp_core_model (
		.i_target(target),
		.i_slow(slow),
		.o_raw(cmp_raw)
	);
	initial begin
		forever #10 core_clk = ~core_clk;
	end

	// ------------------------------------------------------------
	// Access tasks and reporting
	// ------------------------------------------------------------
	task check(input logic [7:0] seen, input logic [7:0] exp,
		input string msg);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : check

	// One-cycle strobe; new fields show at the following falling edge
	task write_ctrl(input logic [7:0] data);
		@(negedge core_clk);
		ctrl_wr = 1'b1;
		ctrl_wdata = data;
		@(negedge core_clk);
		ctrl_wr = 1'b0;
	endtask : write_ctrl

	// Level shows two edges later, the flag one edge after that
	task drive_cmp(input logic level);
		@(negedge core_clk);
		target = level;
		repeat (2) @(negedge core_clk);
		check(out_state, level, "output state");
		check(ctrl[6], level, "read view level");
		@(negedge core_clk);
	endtask : drive_cmp

	task end_of_test;
		$display("checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// Hang guard; the sequence needs well under 200 cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 500) begin
			fail_count++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(negedge core_clk);
		nrst = 1'b1;
		repeat (3) @(negedge core_clk);
		check(ctrl, 8'h00, "reset value");
		check(irq, 1'b0, "irq at reset");
		// Every code pair; bit 6 written high must not stick
		for (int i = 0; i < 16; i++) begin
			write_ctrl({i[0], 3'h4, i[3:0]});
			check(neg, i[1:0], "negative hysteresis");
			check(pos, i[3:2], "positive hysteresis");
			check(ctrl, {i[0], 3'h0, i[3:0]}, "control view");
			check(enable, i[0], "enable bit");
		end
		drive_cmp(1'b1);
		check(rise, 1'b1, "rise flag");
		check(irq, 1'b0, "irq masked");
		irq_enable = 1'b1;
		#1;
		check(irq, 1'b1, "irq from rise");
		slow = 1'b1;
		drive_cmp(1'b0);
		check(fall, 1'b1, "fall flag");
		repeat (8) @(negedge core_clk);
		check({rise, fall}, 2'h3, "flags sticky");
		write_ctrl(8'h80);
		check({rise, fall, irq}, 3'h0, "flags cleared");
		write_ctrl(8'ha0);
		check({rise, fall, irq}, 3'h5, "software rise");
		write_ctrl(8'h90);
		check({rise, fall, irq}, 3'h3, "software fall");
		irq_enable = 1'b0;
		#1;
		check(irq, 1'b0, "irq gated");
		write_ctrl(8'h00);
		check(enable, 1'b0, "comparator off");
		drive_cmp(1'b1);
		check(rise, 1'b1, "rise while off");
		// Clear lands in the very cycle the fall pulse is sampled
		@(negedge core_clk);
		target = 1'b0;
		repeat (2) @(negedge core_clk);
		ctrl_wr = 1'b1;
		ctrl_wdata = 8'h80;
		@(negedge core_clk);
		ctrl_wr = 1'b0;
		check({rise, fall}, 2'h1, "set beats clear");
		end_of_test();
	end
endmodule : test_comparator_edge_flag_control
`default_nettype wire
